// file: hdl/odpd_pkg.sv
/*
  constants, command codes, timing and carrier types for the octal
  converter power-down control.
  assumes a 200 MHz clock and an upstream serial receiver that hands
  over one complete three-byte command word per strobe.
*/
`default_nettype none

package odpd_pkg;

    // *****************************************************
    // geometry
    // *****************************************************
    localparam int N_CH   = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 13;

    // *****************************************************
    // command codes and channel select
    // *****************************************************
    localparam logic [3:0] CMD_WRITE       = 4'h0;
    localparam logic [3:0] CMD_UPDATE      = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDALL = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER_DOWN  = 4'h4;
    localparam logic [3:0] CH_ALL          = 4'hF;

    // *****************************************************
    // reset values
    // *****************************************************
    localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;
    localparam logic [N_CH-1:0]   PD_RST   = 8'h00;

    // *****************************************************
    // timing
    // *****************************************************
    localparam int CLK_PERIOD_NS  = 5;
    localparam int T_WAKE_NS      = 5000;
    localparam int T_WAKE_HI_V_NS = 12000;
    localparam int T_WAKE_LO_V_NS = 30000;
    // least times: round up
    localparam int WAKE_CYC      = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_HI_V_CYC = (T_WAKE_HI_V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_LO_V_CYC = (T_WAKE_LO_V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // *****************************************************
    // carrier types
    // *****************************************************
    typedef struct packed {
        logic [3:0]        command_code;
        logic [3:0]        channel_select;
        logic [DATA_W-1:0] data;
    } odpd_cmd_s;

    typedef struct packed {
        logic buf_en;
        logic ref_en;
        logic pulldown_en;
        logic settle_en;
    } odpd_ana_s;

endpackage : odpd_pkg

`default_nettype wire

// file: hdl/odpd_wake_timer.sv
/*
  one channel's power-up delay counter.
  assumes the caller picks the delay length at the start pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module odpd_wake_timer
    import odpd_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_len,
    output logic                  o_busy
);
    import odpd_pkg::*;

    typedef enum logic {ODPD_IDLE, ODPD_WAIT} odpd_tmr_e;

    odpd_tmr_e        state_r;
    odpd_tmr_e        state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // *****************************************************
    // count down
    // *****************************************************
    // a fresh start restarts the wait: the later update governs
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ODPD_IDLE:
            begin
                if (i_start)
                begin
                    state_nxt = ODPD_WAIT;
                    cnt_nxt   = i_len - 13'h0001;
                end
            end
            ODPD_WAIT:
            begin
                if (i_start)
                    cnt_nxt = i_len - 13'h0001;
                else if (cnt_r == '0)
                    state_nxt = ODPD_IDLE;
                else
                    cnt_nxt = cnt_r - 13'h0001;
            end
            default:
                state_nxt = ODPD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_r <= ODPD_IDLE;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign o_busy = (state_r == ODPD_WAIT);

endmodule : odpd_wake_timer

`default_nettype wire

// file: hdl/odpd_ctrl.sv
/*
  per-channel power-down control of an octal voltage-output converter:
  command decode, holding and active code registers, power-down flags,
  bias control and power-up delay timing.
  assumes serial framing and addressing are done upstream; each
  i_cmd_valid pulse carries one complete three-byte command word.
*/
`timescale 1ns/1ps
`default_nettype none

module odpd_ctrl
    import odpd_pkg::*;
#(
    parameter int WAKE_CYCLES      = WAKE_CYC,
    parameter int WAKE_HI_V_CYCLES = WAKE_HI_V_CYC,
    parameter int WAKE_LO_V_CYCLES = WAKE_LO_V_CYC
)
(
    input  wire logic                           i_clk,
    input  wire logic                           i_rst,
    input  wire logic                           i_cmd_valid,
    input  wire odpd_pkg::odpd_cmd_s            i_cmd,
    input  wire logic                           i_supply_low,
    output logic [odpd_pkg::N_CH-1:0][odpd_pkg::DATA_W-1:0] o_hold_code,
    output logic [odpd_pkg::N_CH-1:0][odpd_pkg::DATA_W-1:0] o_active_code,
    output logic [odpd_pkg::N_CH-1:0]           o_power_down,
    output odpd_pkg::odpd_ana_s [odpd_pkg::N_CH-1:0] o_analog,
    output logic                                o_bias_en
);
    import odpd_pkg::*;

    // *****************************************************
    // elaboration checks
    // *****************************************************
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W))
    begin : g_bad_wake
        $error("wake count out of range");
    end
    if (WAKE_HI_V_CYCLES < 1 || WAKE_HI_V_CYCLES >= (1 << CNT_W))
    begin : g_bad_hi
        $error("high-supply wake count out of range");
    end
    if (WAKE_LO_V_CYCLES < 1 || WAKE_LO_V_CYCLES >= (1 << CNT_W))
    begin : g_bad_lo
        $error("low-supply wake count out of range");
    end
    // select decode below serves exactly eight channels of 16-bit codes
    if (N_CH != 8 || DATA_W != 16)
    begin : g_bad_geom
        $error("channel geometry not supported");
    end
    // the timer counter must be wide enough and not absurdly wide
    if (CNT_W < 1 || CNT_W > 16)
    begin : g_bad_cnt
        $error("counter width not supported");
    end

    localparam logic [CNT_W-1:0] LEN_SHORT = CNT_W'(WAKE_CYCLES);
    localparam logic [CNT_W-1:0] LEN_HI_V  = CNT_W'(WAKE_HI_V_CYCLES);
    localparam logic [CNT_W-1:0] LEN_LO_V  = CNT_W'(WAKE_LO_V_CYCLES);

    // reset analog state: buffer and reference on, pull-down off, settled
    localparam odpd_ana_s ANA_RST = '{buf_en: 1'b1, ref_en: 1'b1,
                                      pulldown_en: 1'b0, settle_en: 1'b1};

    // *****************************************************
    // state
    // *****************************************************
    // eight channels of sixteen bits is small enough to stay in plain
    // flops; a memory would cost a read port per channel anyway
    logic [N_CH-1:0][DATA_W-1:0] hold_r;
    logic [N_CH-1:0][DATA_W-1:0] hold_nxt;
    logic [N_CH-1:0][DATA_W-1:0] active_r;
    logic [N_CH-1:0][DATA_W-1:0] active_nxt;
    logic [N_CH-1:0]             pd_r;
    logic [N_CH-1:0]             pd_nxt;

    // *****************************************************
    // command decode
    // *****************************************************
    // field split
    wire [3:0] cmd_code = i_cmd.command_code;
    wire [3:0] cmd_sel  = i_cmd.channel_select;

    // unlisted select values address no channel
    wire            sel_one  = (cmd_sel < 4'h8);
    wire            sel_all  = (cmd_sel == CH_ALL);
    wire [N_CH-1:0] sel_mask;

    // one compare per channel
    for (genvar k = 0; k < N_CH; k++)
    begin : g_sel
        assign sel_mask[k] = sel_all || (sel_one && (cmd_sel[2:0] == 3'(k)));
    end

    // codes above power-down fall through and change nothing

    wire is_write   = i_cmd_valid && (cmd_code == CMD_WRITE);
    wire is_update  = i_cmd_valid && (cmd_code == CMD_UPDATE);
    wire is_wr_all  = i_cmd_valid && (cmd_code == CMD_WRITE_UPDALL);
    wire is_wr_upd  = i_cmd_valid && (cmd_code == CMD_WRITE_UPDATE);
    wire is_pd      = i_cmd_valid && (cmd_code == CMD_POWER_DOWN);

    wire [N_CH-1:0] wr_mask  = (is_write || is_wr_all || is_wr_upd)
                             ? sel_mask : '0;
    wire [N_CH-1:0] upd_mask = is_wr_all ? {N_CH{1'b1}}
                             : ((is_update || is_wr_upd) ? sel_mask : '0);
    wire [N_CH-1:0] pd_mask  = is_pd ? sel_mask : '0;

    // *****************************************************
    // bias and wake delay choice
    // *****************************************************
    // the choice looks at the flags before this command, so a channel
    // waking from all-down gets the long delay even as bias restarts
    // bias off only when all down
    wire all_down = &pd_r;
    // bias restart needs the long delay
    wire [CNT_W-1:0] long_len = i_supply_low ? LEN_LO_V : LEN_HI_V;
    wire [CNT_W-1:0] wake_len = all_down ? long_len : LEN_SHORT;

    // *****************************************************
    // per-channel registers
    // *****************************************************
    // power-down touches neither register
    always_comb
    begin
        for (int i = 0; i < N_CH; i++)
        begin
            hold_nxt[i]   = wr_mask[i] ? i_cmd.data : hold_r[i];
            active_nxt[i] = upd_mask[i] ? hold_nxt[i] : active_r[i];
        end
    end

    // flag set by power-down, cleared by update
    // a command cannot both power down and update, so no conflict
    assign pd_nxt = (pd_r & ~upd_mask) | pd_mask;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            hold_r   <= {N_CH{CODE_RST}};
            active_r <= {N_CH{CODE_RST}};
            pd_r     <= PD_RST;
        end
        else
        begin
            hold_r   <= hold_nxt;
            active_r <= active_nxt;
            pd_r     <= pd_nxt;
        end
    end

    // *****************************************************
    // per-channel wake timers and analog controls
    // *****************************************************
    // limitation: only settle_en shows the delay; buffer and reference
    // come up at once and the analog side is trusted to ramp them
    // trade-off: a timer per channel costs flops but lets channels
    // wake on their own schedules without a shared arbiter
    logic [N_CH-1:0]      waking;
    odpd_ana_s [N_CH-1:0] ana_nxt;
    odpd_ana_s [N_CH-1:0] ana_r;
    logic                 bias_r;
    wire                  bias_nxt = ~&pd_nxt;

    for (genvar g = 0; g < N_CH; g++)
    begin : g_ch
        // delay only for a channel actually asleep
        wire wake_start = upd_mask[g] && pd_r[g];

        odpd_wake_timer u_wake (
            .i_clk   (i_clk),
            .i_rst   (i_rst),
            .i_start (wake_start),
            .i_len   (wake_len),
            .o_busy  (waking[g])
        );

        // buffer and reference follow the flag
        assign ana_nxt[g].buf_en      = !pd_nxt[g];
        assign ana_nxt[g].ref_en      = !pd_nxt[g];
        assign ana_nxt[g].pulldown_en = pd_nxt[g];
        // a channel powered down again mid-wake stays quiet via its flag
        // settling waits for the delay to run out
        assign ana_nxt[g].settle_en   = !pd_nxt[g] && !waking[g] && !wake_start;
    end

    // registered so the analog controls change with the flags
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ana_r  <= {N_CH{ANA_RST}};
            bias_r <= 1'b1;
        end
        else
        begin
            ana_r  <= ana_nxt;
            bias_r <= bias_nxt;
        end
    end

    // *****************************************************
    // outputs
    // *****************************************************
    // every output comes straight from a flop: no decode glitch leaks out
    assign o_hold_code   = hold_r;
    assign o_active_code = active_r;
    assign o_power_down  = pd_r;
    assign o_analog      = ana_r;
    assign o_bias_en     = bias_r;

endmodule : odpd_ctrl

`default_nettype wire

// file: sim/odpd_assertions.sv
/* port checker for odpd_ctrl.
   assumes one clock, sync reset, bound to every odpd_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module odpd_assertions
    import odpd_pkg::*;
#(
    parameter int WAKE_CYCLES      = 4,
    parameter int WAKE_HI_V_CYCLES = 8,
    parameter int WAKE_LO_V_CYCLES = 12
)
(
    input wire logic                        i_clk,
    input wire logic                        i_rst,
    input wire logic                        i_cmd_valid,
    input wire odpd_cmd_s                   i_cmd,
    input wire logic                        i_supply_low,
    input wire logic [N_CH-1:0][DATA_W-1:0] o_hold_code,
    input wire logic [N_CH-1:0][DATA_W-1:0] o_active_code,
    input wire logic [N_CH-1:0]             o_power_down,
    input wire odpd_ana_s [N_CH-1:0]        o_analog,
    input wire logic                        o_bias_en
);
    // ********
    // helpers
    // ********
    wire logic [3:0] cc = i_cmd.command_code;
    wire logic [3:0] sel = i_cmd.channel_select;
    wire logic [2:0] s = sel[2:0];
    wire logic up_one = (cc == 4'h1 || cc == 4'h3) && (sel == 4'h0 || sel == CH_ALL);
    wire logic up0 = i_cmd_valid && o_power_down[0] && (up_one || cc == 4'h2);
    logic        ana_bad;
    logic [13:0] cnt_r;
    logic        arm_r;
    int          lim_r;
    // only ch0 is timed: enough to see all three delay lengths
    always_comb
    begin
        ana_bad = 1'b0;
        for (int i = 0; i < N_CH; i++)
            if (o_power_down[i] ? o_analog[i] != 4'h2 : o_analog[i][3:1] != 3'h6)
                ana_bad = 1'b1;
    end
    always_ff @(posedge i_clk)
        if (i_rst || up0)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 14'h1;
    always_ff @(posedge i_clk)
        if (i_rst)
            arm_r <= 1'b0;
        else if (up0)
            arm_r <= 1'b1;
        else if (o_analog[0].settle_en)
            arm_r <= 1'b0;
    always_ff @(posedge i_clk)
        if (up0)
            lim_r <= !(&o_power_down) ? WAKE_CYCLES
                   : i_supply_low ? WAKE_LO_V_CYCLES : WAKE_HI_V_CYCLES;
    // ********
    // properties
    // ********
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence pd_cmd;
        i_cmd_valid && cc == CMD_POWER_DOWN;
    endsequence
    sequence pd_one;
        pd_cmd and (!sel[3]);
    endsequence
    sequence upd_one;
        i_cmd_valid && cc == CMD_UPDATE && !sel[3];
    endsequence
    a_pd_sets_flag: assert property (pd_one |=> o_power_down[$past(s)])
        else $error("power-down flag not set");
    a_pd_keeps_regs: assert property (pd_cmd |=> $stable(o_hold_code) && $stable(o_active_code))
        else $error("registers changed by power-down");
    a_bias_follows: assert property (o_bias_en == !(&o_power_down))
        else $error("bias enable wrong");
    a_analog_state: assert property (!ana_bad)
        else $error("analog controls wrong");
    a_upd_wakes: assert property (upd_one |=> !o_power_down[$past(s)]
        && o_active_code[$past(s)] == $past(o_hold_code[s]))
        else $error("update did not wake or copy");
    a_wr_upd_data: assert property ((i_cmd_valid && cc == 4'h3 && !sel[3])
        |=> o_active_code[$past(s)] == $past(i_cmd.data))
        else $error("write and update lost data");
    a_bad_code_idle: assert property ((i_cmd_valid && cc > 4'h4) |=> $stable(o_power_down)
        && $stable(o_hold_code) && $stable(o_active_code))
        else $error("unknown command had effect");
    a_wake_time: assert property ((arm_r && o_analog[0].settle_en) |-> cnt_r >= lim_r
        && cnt_r <= lim_r + 2)
        else $error("wake delay wrong");
    a_wake_bound: assert property (arm_r |-> cnt_r <= lim_r + 2)
        else $error("wake delay overran");
endmodule : odpd_assertions
bind odpd_ctrl odpd_assertions #(.WAKE_CYCLES(WAKE_CYCLES),
    .WAKE_HI_V_CYCLES(WAKE_HI_V_CYCLES), .WAKE_LO_V_CYCLES(WAKE_LO_V_CYCLES)) chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_supply_low(i_supply_low), .o_hold_code(o_hold_code), .o_active_code(o_active_code),
    .o_power_down(o_power_down), .o_analog(o_analog), .o_bias_en(o_bias_en));
`default_nettype wire

// file: sim/odpd_master.sv
/* command source standing in for the serial receiver.
   assumes callers run in one process, stepping at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module odpd_master
    import odpd_pkg::*;
(
    input  wire logic  i_clk,
    output logic       o_cmd_valid,
    output odpd_cmd_s  o_cmd
);
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd = 24'h5A5A5A;
    end
    task automatic send(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
        @(negedge i_clk);
        o_cmd_valid = 1'b1;
        o_cmd = {c, s, d};
    endtask : send
    // word flips while idle, no stale value
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge i_clk);
            o_cmd_valid = 1'b0;
            o_cmd = ~o_cmd;
        end
    endtask : idle
endmodule : odpd_master
`default_nettype wire

// file: sim/tb.sv
/* testbench for odpd_ctrl.
   assumes the checker is bound in; short wake counts. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import odpd_pkg::*;
    localparam int W = 4;
    localparam int HI = 8;
    localparam int LO = 12;
    logic i_clk, i_rst, supply_low, cmd_valid, bias;
    odpd_cmd_s cmd;
    logic [N_CH-1:0][DATA_W-1:0] hold, act, m_hold, m_act;
    logic [N_CH-1:0] pd, m_pd;
    odpd_ana_s [N_CH-1:0] ana;
    logic [264:0] exp_q[$];
    logic [3:0] c, s;
    int fail_count, num_checks, seed;
    odpd_ctrl #(.WAKE_CYCLES(W), .WAKE_HI_V_CYCLES(HI), .WAKE_LO_V_CYCLES(LO)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_supply_low(supply_low), .o_hold_code(hold), .o_active_code(act),
        .o_power_down(pd), .o_analog(ana), .o_bias_en(bias));
    odpd_master mst (.i_clk(i_clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic check(input string what, input logic [264:0] e, input logic [264:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // reference update, then send
    task automatic put(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
        logic [N_CH-1:0] m;
        m = s == CH_ALL ? 8'hFF : s[3] ? 8'h00 : 8'h01 << s[2:0];
        for (int i = 0; i < N_CH; i++)
        begin
            if (m[i] && c inside {4'h0, 4'h2, 4'h3})
                m_hold[i] = d;
            if ((m[i] && c inside {4'h1, 4'h3}) || c == 4'h2)
                m_act[i] = m_hold[i];
            if ((m[i] && c inside {4'h1, 4'h3}) || c == 4'h2)
                m_pd[i] = 1'b0;
            if (m[i] && c == 4'h4)
                m_pd[i] = 1'b1;
        end
        exp_q.push_back({m_pd, ~&m_pd, m_hold, m_act});
        mst.send(c, s, d);
    endtask : put
    // wake ch0 and count cycles until settling starts
    task automatic wake(input logic [3:0] c, input logic [3:0] s, input int len);
        int n;
        put(c, s, 16'(unsigned'($random(seed))));
        mst.idle(1);
        n = 1;
        while (ana[0].settle_en !== 1'b1 && n < 200)
        begin
            mst.idle(1);
            n++;
        end
        check("wake delay", 1, n >= len + 1 && n <= len + 3);
        mst.idle(2);
    endtask : wake
    always @(posedge i_clk)
        if (cmd_valid === 1'b1 && !i_rst)
        begin
            @(negedge i_clk);
            check("outputs", exp_q.pop_front(), {pd, bias, hold, act});
        end
    initial
    begin
        #(20000 * 5);
        fail_count++;
        stop_test();
    end
    initial
    begin
        seed = 74740;
        {m_hold, m_act, m_pd} = '0;
        supply_low = 1'b0;
        i_rst = 1'b1;
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        check("reset outputs", {8'h00, 1'b1, 256'h0}, {pd, bias, hold, act});
        check("reset analog", {8{4'hD}}, ana);
        $display("test reset done");
        // ch0 kept out so its wake timing stays clean
        repeat (300)
        begin
            c = 4'($random(seed));
            s = 4'($random(seed));
            s = (s == 4'h0 || s == CH_ALL) ? 4'h1 : s;
            c = c == 4'h2 ? 4'h3 : c;
            supply_low = 1'($random(seed));
            put(c, s, 16'(unsigned'($random(seed))));
        end
        mst.idle(2);
        $display("test random traffic done");
        put(4'h2, CH_ALL, 16'h1234);
        mst.idle(LO + 4);
        put(4'h4, 4'h0, 16'hFFFF);
        wake(4'h1, 4'h0, W);
        put(4'h4, CH_ALL, 16'h0F0F);
        supply_low = 1'b0;
        wake(4'h1, 4'h0, HI);
        put(4'h4, 4'h0, 16'h00FF);
        supply_low = 1'b1;
        wake(4'h2, 4'h3, LO);
        $display("test wake delays done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
